// *** defhn_pkg.sv ***
// Shared constants and types for the dual event queue block.
package defhn_pkg;

  // ----------------------------------------------------------------
  // Register bus and register map
  // ----------------------------------------------------------------
  localparam int AXI_AW = 12;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_WMARK = 8'h01;
  localparam logic [7:0] IDX_LATENCY = 8'h02;
  localparam logic [7:0] IDX_REQ = 8'h03;
  localparam logic [7:0] IDX_RATES = 8'h04;
  localparam logic [7:0] IDX_STATUS = 8'h05;
  localparam logic [7:0] IDX_WAKE_DATA = 8'h06;
  localparam logic [7:0] IDX_NONWAKE_DATA = 8'h07;
  localparam logic [7:0] IDX_HOST_LINK_CONTROL = 8'h55;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_WAKE_IRQ_EN = 0;
  localparam int CTRL_NONWAKE_SLEEP_IRQ = 1;
  localparam int CTRL_META_OVF_EN = 2;
  localparam int CTRL_META_WM_EN = 3;
  localparam int CTRL_META_OVF_IMM = 4;
  localparam int CTRL_META_WM_IMM = 5;
  localparam int HLC_HOST_ASLEEP_FLAG = 5;
  localparam int STAT_OVF_WAKE = 16;
  localparam int STAT_OVF_NONWAKE = 17;
  localparam int STAT_CORE_AWAKE = 18;
  localparam int STAT_IRQ = 19;
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] HLC_RST = 8'h00;
  localparam logic [15:0] WMARK_RST = 16'h0000;
  localparam logic [15:0] LATENCY_RST = 16'h0000;
  localparam logic [7:0] REQ_RST = 8'h00;
  localparam logic [23:0] RATES_RST = 24'h924924;

  // ----------------------------------------------------------------
  // Event identifiers and rates
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 8;
  localparam logic [7:0] ID_NONWAKE_BASE = 8'h01;
  localparam logic [7:0] ID_WAKE_BASE = 8'h21;
  localparam logic [7:0] ID_TIMESTAMP = 8'hFC;
  localparam logic [7:0] ID_META = 8'hFE;
  localparam logic [23:0] META_OVERFLOW = 24'h000001;
  localparam logic [23:0] META_WATERMARK = 24'h000002;
  // Rate codes: 0 = 200 Hz, 1 = 100, 2 = 50, 3 = 25, 4 = 12.5 Hz.
  localparam logic [2:0] RATE_CODE_MAX = 3'h4;
  localparam int RAW_RATE_MAX_HZ = 200;
  localparam int CLK_HZ = 10000000;
  localparam int SAMPLE_GAP_CYC = CLK_HZ / RAW_RATE_MAX_HZ;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_TS_WAKE = 3'b001,
    SQ_TS_NONWAKE = 3'b010,
    SQ_SAMPLE = 3'b011,
    SQ_META = 3'b100
  } defhn_seq_t;

  typedef struct packed {
    logic [7:0] id;
    logic [23:0] payload;
  } defhn_event_t;

  typedef struct packed {
    logic awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AXI_AW-1:0] araddr;
    logic rready;
  } defhn_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } defhn_axil_rsp_t;

endpackage

// *** defhn_mem.sv ***
// Event storage memory with a registered, write-through read port.
`timescale 1ns/1ps
module defhn_mem #(
  parameter int DW = 32,
  parameter int AW = 5
) (
  input wire logic aclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_ff;

  // The read port shows the word written in the same cycle, so the
  // head of an empty queue is valid one edge after its first write.
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      if (we && (waddr == raddr)) begin
        rdata_ff <= wdata;
      end else begin
        rdata_ff <= mem[raddr];
      end
    end
  end

  assign rdata = rdata_ff;
endmodule

// *** defhn_top.sv ***
// Dual event queue with host notification, rate subsampling and power.
//
// Summary of operation
// - Two output queues, wakeup and non-wakeup; every event passes one of them.
// - By default the non-wakeup queue never interrupts a sleeping host.
// - Full non-wakeup queue with sleeping host drops oldest entries for new.
// - Wakeup queue may interrupt a sleeping host, as configured.
// - Interrupt when wakeup queue fill reaches the wakeup watermark.
// - Interrupt when oldest wakeup event is older than the report latency.
// - Each event is the source identifier followed by its payload.
// - Each source has distinct wakeup and non-wakeup identifiers.
// - Timestamps and meta events use identifiers outside the sensor range.
// - One timestamp event precedes each group of simultaneous samples.
// - Raw samples enter the core at no more than 200 Hz.
// - Internal rates are 200, 100, 50, 25 and 12.5 Hz.
// - Output samples subsample an internal rate within 90 to 210 percent.
// - One internal rate is chosen from which every requested rate derives.
// - After startup nothing is requested; sensors standby, core asleep.
// - Requesting a source enables its sensor and switches fusion mode.
// - Each sample wakes the core; it sleeps again when processing ends.
// - Host selects which meta events enter the queues.
// - Host selects per meta kind immediate interrupt or batching.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module defhn_top
  import defhn_pkg::*;
#(
  parameter int FIFO_AW = 5,
  parameter int SAMPLE_GAP = defhn_pkg::SAMPLE_GAP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input defhn_pkg::defhn_axil_req_t axi_req,
  output defhn_pkg::defhn_axil_rsp_t axi_rsp,
  input wire logic sample_clk,
  input wire logic [23:0] sample_data,
  output logic host_irq,
  output logic [7:0] sensor_enable,
  output logic fusion_run,
  output logic [2:0] fusion_rate_code,
  output logic core_awake
);
  localparam int CW = FIFO_AW + 1;
  localparam logic [CW-1:0] DEPTH = CW'(1 << FIFO_AW);

  typedef struct packed {
    logic s1_clk;
    logic s2_clk;
    logic s3_clk;
    logic [23:0] s1_dat;
    logic [23:0] s2_dat;
    logic [15:0] gap;
    logic [7:0] ctrl;
    logic [7:0] hlc;
    logic [15:0] wmark;
    logic [15:0] latency;
    logic [7:0] req;
    logic [7:0] wsel;
    logic [23:0] rates;
    logic [2:0] int_code;
    logic [FIFO_AW-1:0] wr_w;
    logic [FIFO_AW-1:0] rd_w;
    logic [CW-1:0] cnt_w;
    logic [FIFO_AW-1:0] wr_n;
    logic [FIFO_AW-1:0] rd_n;
    logic [CW-1:0] cnt_n;
    defhn_seq_t seq;
    logic [2:0] src;
    logic [7:0] due;
    logic [3:0] tick;
    logic [23:0] ts;
    logic [23:0] sample;
    logic [15:0] age;
    logic ovf_w;
    logic ovf_n;
    logic [1:0] meta_pend;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [AXI_AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } defhn_state_t;

  defhn_state_t st_ff;
  defhn_state_t nxt_st;
  logic [31:0] head_w;
  logic [31:0] head_n;
  logic push_w;
  logic push_n;
  defhn_event_t push_word;
  logic we_w;
  logic we_n;
  logic [7:0] due_now;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Returns 1 when the byte address maps to a register.
  function automatic logic addr_hit(input logic [AXI_AW-1:0] a);
    logic [7:0] idx;
    idx = a[9:2];
    if (a[AXI_AW-1:10] != '0) begin
      return 1'b0;
    end else if (idx <= IDX_NONWAKE_DATA) begin
      return 1'b1;
    end else if (idx == IDX_HOST_LINK_CONTROL) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [2:0] rate_of(input logic [23:0] rates,
      input int i);
    logic [2:0] c;
    c = rates[i*3 +: 3];
    return (c > RATE_CODE_MAX) ? RATE_CODE_MAX : c;
  endfunction

  // ----------------------------------------------------------------
  // Per-source subsampling decision
  // ----------------------------------------------------------------
  // Rates are powers of two apart, so every requested rate divides the
  // fastest one exactly and is delivered at 100 percent.
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_due
      assign due_now[g] = st_ff.req[g] &&
        ((st_ff.tick & 4'((5'h01 << rate_of(st_ff.rates, g)) - 5'h01))
         == 4'h0);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic tick_edge;
    logic asleep;
    logic rd_fire;
    logic wr_fire;
    logic pop_w;
    logic pop_n;
    logic [7:0] ridx;
    logic [7:0] widx;
    logic [31:0] wv;
    logic [2:0] ic;
    logic cause;
    tick_edge = 1'b0;
    asleep = st_ff.hlc[HLC_HOST_ASLEEP_FLAG];
    rd_fire = 1'b0;
    wr_fire = 1'b0;
    pop_w = 1'b0;
    pop_n = 1'b0;
    ridx = axi_req.araddr[9:2];
    widx = st_ff.awaddr[9:2];
    wv = 32'h0000_0000;
    ic = RATE_CODE_MAX;
    cause = 1'b0;
    push_w = 1'b0;
    push_n = 1'b0;
    push_word = '0;
    we_w = 1'b0;
    we_n = 1'b0;
    nxt_st = st_ff;

    // Pin inputs pass two flops; the second feeds logic, and a third clock flop finds the edge.
    nxt_st.s1_clk = sample_clk;
    nxt_st.s2_clk = st_ff.s1_clk;
    nxt_st.s3_clk = st_ff.s2_clk;
    nxt_st.s1_dat = sample_data;
    nxt_st.s2_dat = st_ff.s1_dat;
    if (st_ff.gap != 16'h0000) begin
      nxt_st.gap = st_ff.gap - 16'h0001;
    end
    // Edges closer than the 200 Hz raw period are ignored.
    if (st_ff.s2_clk && !st_ff.s3_clk && st_ff.gap == 16'h0000) begin
      tick_edge = 1'b1;
      nxt_st.gap = 16'(SAMPLE_GAP - 1);
    end

    // The fastest requested rate becomes the internal rate.
    for (int i = 0; i < NUM_SRC; i++) begin
      if (st_ff.req[i] && rate_of(st_ff.rates, i) < ic) begin
        ic = rate_of(st_ff.rates, i);
      end
    end
    nxt_st.int_code = ic;

    // Event sequencer; the core is awake outside SQ_IDLE.
    case (st_ff.seq)
      SQ_IDLE: begin
        if (tick_edge && st_ff.req != 8'h00) begin
          nxt_st.due = due_now;
          nxt_st.sample = st_ff.s2_dat;
          nxt_st.tick = st_ff.tick + 4'h1;
          nxt_st.ts = st_ff.ts + 24'h000001;
          nxt_st.seq = SQ_TS_WAKE;
        end
      end
      SQ_TS_WAKE: begin
        // One timestamp heads each group, per queue.
        if ((st_ff.due & st_ff.wsel) != 8'h00) begin
          push_w = 1'b1;
          push_word = '{id: ID_TIMESTAMP, payload: st_ff.ts};
        end
        nxt_st.seq = SQ_TS_NONWAKE;
      end
      SQ_TS_NONWAKE: begin
        if ((st_ff.due & ~st_ff.wsel) != 8'h00) begin
          push_n = 1'b1;
          push_word = '{id: ID_TIMESTAMP, payload: st_ff.ts};
        end
        nxt_st.src = 3'h0;
        nxt_st.seq = SQ_SAMPLE;
      end
      SQ_SAMPLE: begin
        if (st_ff.due[st_ff.src]) begin
          // Identifier first, then payload; wakeup and non-wakeup
          // variants carry distinct identifiers.
          push_word.payload = st_ff.sample;
          if (st_ff.wsel[st_ff.src]) begin
            push_w = 1'b1;
            push_word.id = ID_WAKE_BASE + {5'h00, st_ff.src};
          end else begin
            push_n = 1'b1;
            push_word.id = ID_NONWAKE_BASE + {5'h00, st_ff.src};
          end
        end
        nxt_st.src = st_ff.src + 3'h1;
        if (st_ff.src == 3'h7) begin
          nxt_st.seq = SQ_META;
        end
      end
      SQ_META: begin
        // Only the kinds the host enabled are queued.
        if (st_ff.meta_pend[0] && st_ff.ctrl[CTRL_META_OVF_EN]) begin
          push_w = 1'b1;
          push_word = '{id: ID_META, payload: META_OVERFLOW};
          nxt_st.meta_pend[0] = 1'b0;
        end else if (st_ff.meta_pend[1] && st_ff.ctrl[CTRL_META_WM_EN]) begin
          push_w = 1'b1;
          push_word = '{id: ID_META, payload: META_WATERMARK};
          nxt_st.meta_pend[1] = 1'b0;
        end else begin
          nxt_st.meta_pend = 2'b00;
          nxt_st.seq = SQ_IDLE;
        end
        // An immediate meta kind raises the request at once.
        if (push_w && (push_word.payload == META_OVERFLOW) &&
            st_ff.ctrl[CTRL_META_OVF_IMM]) begin
          cause = 1'b1;
        end
        if (push_w && (push_word.payload == META_WATERMARK) &&
            st_ff.ctrl[CTRL_META_WM_IMM]) begin
          cause = 1'b1;
        end
      end
      default: begin
        nxt_st.seq = SQ_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Register bus: write channel
    // ----------------------------------------------------------------
    if (axi_rsp.awready && axi_req.awvalid) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = axi_req.awaddr;
    end
    if (axi_rsp.wready && axi_req.wvalid) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = axi_req.wdata;
      nxt_st.wstrb = axi_req.wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      wr_fire = 1'b1;
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = addr_hit(st_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_ff.bvalid && axi_req.bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (wr_fire && addr_hit(st_ff.awaddr)) begin
      if (widx == IDX_CTRL) begin
        wv = merge_strb({24'h0, st_ff.ctrl}, st_ff.wdata, st_ff.wstrb);
        nxt_st.ctrl = wv[7:0];
      end else if (widx == IDX_WMARK) begin
        wv = merge_strb({16'h0, st_ff.wmark}, st_ff.wdata, st_ff.wstrb);
        nxt_st.wmark = wv[15:0];
      end else if (widx == IDX_LATENCY) begin
        wv = merge_strb({16'h0, st_ff.latency}, st_ff.wdata,
                        st_ff.wstrb);
        nxt_st.latency = wv[15:0];
      end else if (widx == IDX_REQ) begin
        wv = merge_strb({16'h0, st_ff.wsel, st_ff.req}, st_ff.wdata,
                        st_ff.wstrb);
        nxt_st.req = wv[7:0];
        nxt_st.wsel = wv[15:8];
      end else if (widx == IDX_RATES) begin
        wv = merge_strb({8'h0, st_ff.rates}, st_ff.wdata, st_ff.wstrb);
        nxt_st.rates = wv[23:0];
      end else if (widx == IDX_STATUS) begin
        // Write one to clear an overflow flag.
        if (st_ff.wstrb[2] && st_ff.wdata[STAT_OVF_WAKE]) begin
          nxt_st.ovf_w = 1'b0;
        end
        if (st_ff.wstrb[2] && st_ff.wdata[STAT_OVF_NONWAKE]) begin
          nxt_st.ovf_n = 1'b0;
        end
      end else if (widx == IDX_HOST_LINK_CONTROL) begin
        wv = merge_strb({24'h0, st_ff.hlc}, st_ff.wdata, st_ff.wstrb);
        nxt_st.hlc = wv[7:0];
      end
    end

    // ----------------------------------------------------------------
    // Register bus: read channel; reading a queue pops its head
    // ----------------------------------------------------------------
    if (axi_rsp.arready && axi_req.arvalid) begin
      rd_fire = 1'b1;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      if (!addr_hit(axi_req.araddr)) begin
        nxt_st.rresp = RESP_SLVERR;
      end else if (ridx == IDX_CTRL) begin
        nxt_st.rdata = {24'h0, st_ff.ctrl};
      end else if (ridx == IDX_WMARK) begin
        nxt_st.rdata = {16'h0, st_ff.wmark};
      end else if (ridx == IDX_LATENCY) begin
        nxt_st.rdata = {16'h0, st_ff.latency};
      end else if (ridx == IDX_REQ) begin
        nxt_st.rdata = {16'h0, st_ff.wsel, st_ff.req};
      end else if (ridx == IDX_RATES) begin
        nxt_st.rdata = {8'h0, st_ff.rates};
      end else if (ridx == IDX_STATUS) begin
        nxt_st.rdata[7:0] = 8'(st_ff.cnt_w);
        nxt_st.rdata[15:8] = 8'(st_ff.cnt_n);
        nxt_st.rdata[STAT_OVF_WAKE] = st_ff.ovf_w;
        nxt_st.rdata[STAT_OVF_NONWAKE] = st_ff.ovf_n;
        nxt_st.rdata[STAT_CORE_AWAKE] = (st_ff.seq != SQ_IDLE);
        nxt_st.rdata[STAT_IRQ] = st_ff.irq;
      end else if (ridx == IDX_WAKE_DATA) begin
        if (st_ff.cnt_w != '0) begin
          nxt_st.rdata = head_w;
          pop_w = 1'b1;
        end
      end else if (ridx == IDX_NONWAKE_DATA) begin
        if (st_ff.cnt_n != '0) begin
          nxt_st.rdata = head_n;
          pop_n = 1'b1;
        end
      end else if (ridx == IDX_HOST_LINK_CONTROL) begin
        nxt_st.rdata = {24'h0, st_ff.hlc};
      end
    end
    if (st_ff.rvalid && axi_req.rready && !rd_fire) begin
      nxt_st.rvalid = 1'b0;
    end

    // ----------------------------------------------------------------
    // Queue pointers
    // ----------------------------------------------------------------
    if (pop_w) begin
      nxt_st.rd_w = st_ff.rd_w + 1'b1;
      nxt_st.cnt_w = st_ff.cnt_w - 1'b1;
    end
    if (push_w) begin
      if (st_ff.cnt_w != DEPTH || pop_w) begin
        we_w = 1'b1;
        nxt_st.wr_w = st_ff.wr_w + 1'b1;
        nxt_st.cnt_w = nxt_st.cnt_w + 1'b1;
      end else begin
        // A full wakeup queue drops the new event and flags it.
        nxt_st.ovf_w = 1'b1;
        nxt_st.meta_pend[0] = 1'b1;
      end
    end
    if (pop_n) begin
      nxt_st.rd_n = st_ff.rd_n + 1'b1;
      nxt_st.cnt_n = st_ff.cnt_n - 1'b1;
    end
    if (push_n) begin
      if (st_ff.cnt_n != DEPTH || pop_n) begin
        we_n = 1'b1;
        nxt_st.wr_n = st_ff.wr_n + 1'b1;
        nxt_st.cnt_n = nxt_st.cnt_n + 1'b1;
      end else if (asleep) begin
        // Overwrite the oldest entry so fresh data survive.
        we_n = 1'b1;
        nxt_st.wr_n = st_ff.wr_n + 1'b1;
        nxt_st.rd_n = st_ff.rd_n + 1'b1;
        nxt_st.ovf_n = 1'b1;
        nxt_st.meta_pend[0] = 1'b1;
      end else begin
        nxt_st.ovf_n = 1'b1;
        nxt_st.meta_pend[0] = 1'b1;
      end
    end
    if (we_w && st_ff.wmark[7:0] != 8'h00 &&
        8'(nxt_st.cnt_w) == st_ff.wmark[7:0]) begin
      nxt_st.meta_pend[1] = 1'b1;
    end

    // ----------------------------------------------------------------
    // Report latency and host interrupt request
    // ----------------------------------------------------------------
    // Age counts raw ticks and restarts when the oldest entry leaves.
    if (st_ff.cnt_w == '0 || pop_w) begin
      nxt_st.age = 16'h0000;
    end else if (tick_edge && st_ff.age != 16'hFFFF) begin
      nxt_st.age = st_ff.age + 16'h0001;
    end
    if (st_ff.ctrl[CTRL_WAKE_IRQ_EN]) begin
      // Wakeup causes ignore the host sleep flag.
      if (st_ff.wmark[7:0] != 8'h00 &&
          8'(st_ff.cnt_w) >= st_ff.wmark[7:0]) begin
        cause = 1'b1;
      end
      if (st_ff.latency != 16'h0000 && st_ff.age >= st_ff.latency) begin
        cause = 1'b1;
      end
    end
    if (st_ff.wmark[15:8] != 8'h00 &&
        8'(st_ff.cnt_n) >= st_ff.wmark[15:8] &&
        (!asleep || st_ff.ctrl[CTRL_NONWAKE_SLEEP_IRQ])) begin
      cause = 1'b1;
    end
    // Held until both queues are drained; a new cause wins.
    nxt_st.irq = cause ||
      (st_ff.irq && !(nxt_st.cnt_w == '0 && nxt_st.cnt_n == '0));
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.hlc <= HLC_RST;
      st_ff.wmark <= WMARK_RST;
      st_ff.latency <= LATENCY_RST;
      st_ff.req <= REQ_RST;
      st_ff.rates <= RATES_RST;
      st_ff.int_code <= RATE_CODE_MAX;
      st_ff.seq <= SQ_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  defhn_mem #(.DW(32), .AW(FIFO_AW)) u_mem_wake (
    .aclk(aclk),
    .ce(ce),
    .we(we_w),
    .waddr(st_ff.wr_w),
    .wdata(push_word),
    .raddr(nxt_st.rd_w),
    .rdata(head_w)
  );

  defhn_mem #(.DW(32), .AW(FIFO_AW)) u_mem_nonwake (
    .aclk(aclk),
    .ce(ce),
    .we(we_n),
    .waddr(st_ff.wr_n),
    .wdata(push_word),
    .raddr(nxt_st.rd_n),
    .rdata(head_n)
  );

  // Readies drop while the clock enable is low so no beat is lost.
  assign axi_rsp.awready = ce && aresetn && !st_ff.aw_got && !st_ff.bvalid;
  assign axi_rsp.wready = ce && aresetn && !st_ff.w_got && !st_ff.bvalid;
  assign axi_rsp.bvalid = st_ff.bvalid;
  assign axi_rsp.bresp = st_ff.bresp;
  assign axi_rsp.arready = ce && aresetn &&
    (!st_ff.rvalid || axi_req.rready);
  assign axi_rsp.rvalid = st_ff.rvalid;
  assign axi_rsp.rdata = st_ff.rdata;
  assign axi_rsp.rresp = st_ff.rresp;
  assign host_irq = st_ff.irq;
  assign sensor_enable = st_ff.req;
  assign fusion_run = (st_ff.req != 8'h00);
  assign fusion_rate_code = st_ff.int_code;
  assign core_awake = (st_ff.seq != SQ_IDLE);
endmodule

// *** defhn_props.sv ***
// Concurrent checks on the ports of the dual event queue block.
`timescale 1ns/1ps
module defhn_props
  import defhn_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input defhn_pkg::defhn_axil_req_t axi_req,
  input defhn_pkg::defhn_axil_rsp_t axi_rsp,
  input wire logic sample_clk,
  input wire logic [23:0] sample_data,
  input wire logic host_irq,
  input wire logic [7:0] sensor_enable,
  input wire logic fusion_run,
  input wire logic [2:0] fusion_rate_code,
  input wire logic core_awake
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  a_wr_resp_time: assert property (
    s_wr_both |-> ##[1:2] axi_rsp.bvalid) else $error("write response late");
  a_rd_resp_time: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data late");
  a_bresp_holds: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
    else $error("write response dropped");
  a_rdata_holds: assert property (
    axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata)) else $error("read data moved");
  a_run_follows_req: assert property (
    fusion_run == (sensor_enable != 0)) else $error("fusion run wrong");
  a_idle_rate_slow: assert property (sensor_enable == 0 &&
    $past(sensor_enable) == 0 |-> fusion_rate_code == 3'h4)
    else $error("idle rate not slowest");
  a_rate_code_legal: assert property (fusion_rate_code <= 3'h4)
    else $error("rate code out of range");
  a_core_sleeps_again: assert property ($rose(core_awake) |->
    ##[1:30] !core_awake) else $error("core stays awake");
  a_wake_needs_req: assert property ($rose(core_awake) |-> fusion_run)
    else $error("core woke with nothing requested");
endmodule
bind defhn_top defhn_props u_props (.*);

// *** defhn_sensor_model.sv ***
// Raw sensor stand-in: one sample edge per 800 ns while enabled.
`timescale 1ns/1ps
module defhn_sensor_model (
  input wire logic en,
  output logic sample_clk,
  output logic [23:0] sample_data
);
  // The clock stands low between frames; data keeps changing so a stale
  // value is never mistaken for a fresh sample.
  initial begin
    sample_clk = 1'b0;
    sample_data = 24'hA5A5A5;
    forever #400 begin
      sample_clk = en ? ~sample_clk : 1'b0;
      if (!sample_clk) sample_data = sample_data + 24'h00010F;
    end
  end
endmodule

// *** test_defhn_top.sv ***
// Register-level testbench for the dual event queue block.
`timescale 1ns/1ps
module test_defhn_top;
  import defhn_pkg::*;
  logic aclk, aresetn, m_en, s_clk, host_irq, f_run, awake;
  logic [23:0] s_data, exp_d;
  logic [7:0] s_en;
  logic [2:0] rate;
  logic [31:0] d;
  logic [1:0] resp;
  defhn_axil_req_t req;
  defhn_axil_rsp_t rsp;
  int mismatches, num_checks;
  defhn_top #(.FIFO_AW(3), .SAMPLE_GAP(4)) dut (.aclk(aclk),
    .aresetn(aresetn), .ce(1'b1), .axi_req(req), .axi_rsp(rsp),
    .sample_clk(s_clk), .sample_data(s_data), .host_irq(host_irq),
    .sensor_enable(s_en), .fusion_run(f_run), .fusion_rate_code(rate),
    .core_awake(awake));
  defhn_sensor_model sens (.en(m_en), .sample_clk(s_clk),
    .sample_data(s_data));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Readies are sampled mid-cycle, where nothing can still be moving.
  task wr(input logic [7:0] i, input logic [31:0] v);
    logic a, w, b;
    req.awaddr <= {2'h0, i, 2'h0};
    req.wdata <= v;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      a = rsp.awready;
      w = rsp.wready;
      b = rsp.bvalid;
      @(posedge aclk);
      if (a) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (!b);
  endtask
  task rd(input logic [7:0] i);
    logic a, b;
    req.araddr <= {2'h0, i, 2'h0};
    req.arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      a = rsp.arready;
      b = rsp.rvalid;
      d = rsp.rdata;
      resp = rsp.rresp;
      @(posedge aclk);
      if (a && req.arvalid) req.arvalid <= 1'b0;
    end while (!b);
  endtask
  task tick;
    m_en <= 1'b1;
    @(posedge s_clk);
    exp_d = s_data;
    repeat (6) @(posedge aclk);
    m_en <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    summarize;
  end
  initial begin
    aresetn = 1'b0;
    m_en = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({s_en, f_run, rate, awake}, {8'h00, 1'b0, 3'h4, 1'b0});
    rd(IDX_CTRL);
    chk(d, CTRL_RST);
    rd(IDX_RATES);
    chk(d, RATES_RST);
    rd(IDX_HOST_LINK_CONTROL);
    chk(d, HLC_RST);
    rd(8'h20);
    chk(resp, RESP_SLVERR);
    wr(IDX_RATES, 32'h0);
    wr(IDX_WMARK, 32'h2);
    wr(IDX_REQ, 32'h0101);
    repeat (2) @(posedge aclk);
    chk({s_en, f_run, rate}, {8'h01, 1'b1, 3'h0});
    tick;
    chk(host_irq, 1'b1);
    rd(IDX_WAKE_DATA);
    chk(d[31:24], ID_TIMESTAMP);
    rd(IDX_WAKE_DATA);
    chk(d, {ID_WAKE_BASE, exp_d});
    repeat (2) @(posedge aclk);
    chk(host_irq, 1'b0);
    wr(IDX_HOST_LINK_CONTROL, 32'h20);
    wr(IDX_WMARK, 32'h0100);
    wr(IDX_REQ, 32'h0002);
    tick;
    chk(host_irq, 1'b0);
    wr(IDX_HOST_LINK_CONTROL, 32'h0);
    repeat (2) @(posedge aclk);
    chk(host_irq, 1'b1);
    rd(IDX_NONWAKE_DATA);
    chk(d[31:24], ID_TIMESTAMP);
    rd(IDX_NONWAKE_DATA);
    chk(d, {ID_NONWAKE_BASE + 8'h01, exp_d});
    repeat (2) @(posedge aclk);
    chk(host_irq, 1'b0);
    // Five sample groups overfill the eight-entry queue of a sleeping host.
    wr(IDX_HOST_LINK_CONTROL, 32'h20);
    wr(IDX_CTRL, 32'h15);
    repeat (5) tick;
    rd(IDX_STATUS);
    chk(d, 32'h000A_0801);
    rd(IDX_WAKE_DATA);
    chk(d, {ID_META, META_OVERFLOW});
    rd(IDX_NONWAKE_DATA);
    chk(d, {ID_TIMESTAMP, 24'h000004});
    summarize;
  end
endmodule
